// File: vsk_pkg.sv
/*
  shared constants, types and register map of the socket packet engine.
  assumes one 40 MHz clock and an APB master with 32-bit data.
*/
`default_nettype none
package vsk_pkg;
  typedef struct packed {
    logic [63:0] src_cid;
    logic [63:0] dst_cid;
    logic [31:0] src_port;
    logic [31:0] dst_port;
    logic [31:0] len;
    logic [15:0] ptype;
    logic [15:0] op;
    logic [31:0] flags;
    logic [31:0] buf_alloc;
    logic [31:0] fwd_cnt;
  } vsk_hdr_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } vsk_apb_req_t;
  typedef struct packed {
    logic [23:0] rsvd;
    logic        cred;
    logic        eor;
    logic        eom;
    logic        trst;
    logic        shut;
    logic        send;
    logic        seq;
    logic        listen;
  } vsk_ctrl_t;
  typedef struct packed {
    logic [24:0] rsvd;
    logic        send_pend;
    logic        store_full;
    logic        cid_err;
    logic        closing;
    logic        connected;
    logic [1:0]  peer_shut;
  } vsk_status_t;
  typedef enum {ST_IDLE, ST_CONN, ST_CLOSING} vsk_state_t;
  localparam logic [15:0] OP_INVALID     = 16'h0;
  localparam logic [15:0] OP_REQUEST     = 16'h1;
  localparam logic [15:0] OP_RESPONSE    = 16'h2;
  localparam logic [15:0] OP_RST         = 16'h3;
  localparam logic [15:0] OP_SHUTDOWN    = 16'h4;
  localparam logic [15:0] OP_RW          = 16'h5;
  localparam logic [15:0] OP_CREDIT_UPD  = 16'h6;
  localparam logic [15:0] OP_CREDIT_REQ  = 16'h7;
  localparam logic [15:0] TYPE_STREAM    = 16'h1;
  localparam logic [15:0] TYPE_SEQPKT    = 16'h2;
  localparam int          SHUT_RX_BIT    = 0;
  localparam int          SHUT_TX_BIT    = 1;
  localparam logic [31:0] EVT_TRANSPORT_RESET = 32'h0;
  localparam logic [63:0] HOST_CID       = 64'h2;
  localparam logic [31:0] CID_RSV_LOW    = 32'h2;
  localparam logic [31:0] CID_RSV_A      = 32'h0fffffff;
  localparam logic [31:0] CID_RSV_B      = 32'hffffffff;
  localparam logic [31:0] CID_RESET      = 32'h3;
  localparam logic [31:0] BUF_ALLOC_RESET = 32'h00010000;
  localparam logic [7:0]  REG_CID_LO     = 8'h00;
  localparam logic [7:0]  REG_CID_HI     = 8'h04;
  localparam logic [7:0]  REG_CTRL       = 8'h08;
  localparam logic [7:0]  REG_TX_LEN     = 8'h0c;
  localparam logic [7:0]  REG_BUF_ALLOC  = 8'h10;
  localparam logic [7:0]  REG_STATUS     = 8'h14;
  localparam logic [7:0]  REG_FWD_CNT    = 8'h18;
  localparam logic [7:0]  REG_PEER_FREE  = 8'h1c;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int DISC_TIMEOUT_US = 1000;
  localparam int DISC_CYC        = (DISC_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: vsk_engine.sv
/*
  device end of a socket packet transport: one connection, reply store,
  credit accounting, disconnect timer, transport reset event, APB registers.
  assumes tx/rx/event queue handshakes are driven from logic on SYS_CLK.
*/
// Behaviour
// RULE1: context id upper word reads zero
// RULE2: reserved context ids are never held
// RULE3: driver reads id, fills event, then rx
// RULE4: header fields in fixed little-endian order
// RULE5: upper cid words filled with zeros
// RULE6: op codes zero through seven
// RULE7: device packets and replies go on rx
// RULE8: driver drains rx while tx full
// RULE9: keep taking tx while rx full
// RULE10: stop taking tx when store exhausted
// RULE11: type one stream, two seqpacket
// RULE12: advertise buffer size and received count
// RULE13: send payload only when credit covers it
// RULE14: answer credit request with credit update
// RULE15: every packet carries current credit fields
// RULE16: driver uses guest id as source
// RULE17: unknown type answered with reset
// RULE18: request answered by response or reset
// RULE19: shutdown bits latch permanently
// RULE20: shutdown then reset, or reset on timeout
// RULE21: seqpacket end of message/record flags
// RULE22: transport reset event with id zero
`timescale 1ns/10ps
`default_nettype none
module vsk_engine
  import vsk_pkg::*;
#(
  parameter int DEPTH      = 4,
  parameter int DISC_CYC_P = DISC_CYC
) (
  // clock and reset
  input  wire logic         SYS_CLK,
  input  wire logic         SRST,
  // register bus
  input  wire vsk_apb_req_t APB_REQ,
  output logic [31:0]       PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  // packets from the driver
  input  wire logic         TX_VALID,
  input  wire vsk_hdr_t     TX_HDR,
  output logic              TX_READY,
  // packets to the driver
  output logic              RX_VALID,
  output vsk_hdr_t          RX_HDR,
  input  wire logic         RX_READY,
  // events to the driver
  output logic              EVT_VALID,
  output logic [31:0]       EVT_ID,
  input  wire logic         EVT_READY
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  vsk_hdr_t    mem [DEPTH];
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [AW-1:0] wp_r, rp_r;
  logic [31:0] cid_r, tx_len_r, buf_alloc_r;
  logic        cid_err_r, listen_r, seq_r, eom_r, eor_r;
  logic        send_pend_r, shut_pend_r, cred_pend_r, rst_pend_r, trst_pend_r;
  vsk_state_t  state_r;
  logic [31:0] lport_r, pport_r, peer_ba_r, peer_fwd_r, tx_cnt_r, fwd_cnt_r;
  logic [1:0]  shut_r;
  logic [31:0] tmr_r;
  logic [31:0] peer_free, rdata;
  logic        hit, acc, xfer, wr;
  logic        tx_acc, type_ok, rep_en, sw_room, send_ok;
  logic        g_rst, g_shut, g_send, g_cred, enq, deq, trst_go;
  logic [15:0] rep_op;
  vsk_hdr_t    h, enq_hdr;
  vsk_ctrl_t   wctl;
  vsk_status_t sts;

  function automatic logic is_rsv(input logic [31:0] v);
    return v <= CID_RSV_LOW || v == CID_RSV_A || v == CID_RSV_B;
  endfunction

  // device-originated and reply headers share one builder
  function automatic vsk_hdr_t mk(input logic [15:0] op, input logic [31:0] flg, input logic [31:0] len,
                                  input logic [31:0] dcid, input logic [31:0] sp, input logic [31:0] dp);
    vsk_hdr_t r; // RULE4
    r.src_cid   = HOST_CID;         // RULE5
    r.dst_cid   = {32'h0, dcid};    // RULE5
    r.src_port  = sp;
    r.dst_port  = dp;
    r.len       = len;
    r.ptype     = seq_r ? TYPE_SEQPKT : TYPE_STREAM; // RULE11
    r.op        = op;               // RULE6
    r.flags     = flg;
    r.buf_alloc = buf_alloc_r;      // RULE12 RULE15
    r.fwd_cnt   = fwd_cnt_r;        // RULE12 RULE15
    return r;
  endfunction

  // apb slave, one wait state
  assign acc  = APB_REQ.psel && APB_REQ.penable;
  assign xfer = acc && PREADY;
  assign wr   = xfer && APB_REQ.pwrite;
  assign wctl = vsk_ctrl_t'(APB_REQ.pwdata);
  assign peer_free = peer_ba_r - (tx_cnt_r - peer_fwd_r); // RULE13

  always_comb begin
    sts = '0;
    sts.send_pend  = send_pend_r;
    sts.store_full = cnt_r == CW'(DEPTH);
    sts.cid_err    = cid_err_r;
    sts.closing    = state_r == ST_CLOSING;
    sts.connected  = state_r == ST_CONN;
    sts.peer_shut  = shut_r;
    hit   = 1'b1;
    rdata = 32'h0;
    case (APB_REQ.paddr)
      REG_CID_LO:    rdata = cid_r;
      REG_CID_HI:    rdata = 32'h0; // RULE1
      REG_CTRL:      rdata = {30'h0, seq_r, listen_r};
      REG_TX_LEN:    rdata = tx_len_r;
      REG_BUF_ALLOC: rdata = buf_alloc_r;
      REG_STATUS:    rdata = 32'(sts);
      REG_FWD_CNT:   rdata = fwd_cnt_r;
      REG_PEER_FREE: rdata = peer_free;
      default:       hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc && !PREADY;
      PRDATA  <= (acc && !PREADY && !APB_REQ.pwrite) ? rdata : 32'h0;
      PSLVERR <= acc && !PREADY && !hit;
    end
  end

  // configuration
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cid_r       <= CID_RESET;
      cid_err_r   <= 1'b0;
      listen_r    <= 1'b0;
      seq_r       <= 1'b0;
      eom_r       <= 1'b0;
      eor_r       <= 1'b0;
      tx_len_r    <= 32'h0;
      buf_alloc_r <= BUF_ALLOC_RESET;
    end else if (wr && hit) begin
      case (APB_REQ.paddr)
        REG_CID_LO: begin
          // a reserved id is refused and flagged, the old id stays
          if (is_rsv(APB_REQ.pwdata)) begin // RULE2
            cid_err_r <= 1'b1;
          end else begin
            cid_r     <= APB_REQ.pwdata;
            cid_err_r <= 1'b0;
          end
        end
        REG_CTRL: begin
          listen_r <= wctl.listen;
          seq_r    <= wctl.seq;
          eom_r    <= wctl.eom;
          eor_r    <= wctl.eor;
        end
        REG_TX_LEN:    tx_len_r    <= APB_REQ.pwdata;
        REG_BUF_ALLOC: buf_alloc_r <= APB_REQ.pwdata;
        default: ;
      endcase
    end
  end

  // decode of a packet taken from tx
  assign tx_acc = TX_VALID && TX_READY;
  assign h      = TX_HDR;

  always_comb begin
    type_ok = h.ptype == TYPE_STREAM || h.ptype == TYPE_SEQPKT; // RULE11
    rep_en  = 1'b0;
    rep_op  = OP_RST;
    if (!type_ok) begin
      rep_en = 1'b1; // RULE17
    end else begin
      case (h.op)
        OP_REQUEST: begin
          rep_en = 1'b1;
          if (listen_r && state_r == ST_IDLE) begin
            rep_op = OP_RESPONSE; // RULE18
          end
        end
        OP_CREDIT_REQ: begin
          rep_en = 1'b1;
          rep_op = OP_CREDIT_UPD; // RULE14
        end
        OP_SHUTDOWN: rep_en = state_r != ST_IDLE && (shut_r | h.flags[1:0]) == 2'b11; // RULE20
        default:     rep_en = 1'b0;
      endcase
    end
  end

  // device-originated packets only use cycles free of tx traffic
  assign sw_room = !tx_acc && cnt_r < CW'(DEPTH);
  assign send_ok = state_r == ST_CONN && !shut_r[SHUT_RX_BIT] && peer_free >= tx_len_r; // RULE13

  always_comb begin
    g_rst  = 1'b0;
    g_shut = 1'b0;
    g_send = 1'b0;
    g_cred = 1'b0;
    if (sw_room) begin
      if (rst_pend_r) begin
        g_rst = 1'b1;
      end else if (shut_pend_r && state_r == ST_CONN) begin
        g_shut = 1'b1;
      end else if (send_pend_r && send_ok) begin
        g_send = 1'b1;
      end else if (cred_pend_r && state_r != ST_IDLE) begin
        g_cred = 1'b1; // RULE14
      end
    end
  end

  always_comb begin
    enq     = 1'b1;
    enq_hdr = mk(OP_RST, 32'h0, 32'h0, cid_r, lport_r, pport_r);
    if (tx_acc && rep_en) begin
      enq_hdr = mk(rep_op, 32'h0, 32'h0, h.src_cid[31:0], h.dst_port, h.src_port); // RULE7
    end else if (g_shut) begin
      enq_hdr = mk(OP_SHUTDOWN, 32'h3, 32'h0, cid_r, lport_r, pport_r); // RULE20
    end else if (g_send) begin
      enq_hdr = mk(OP_RW, seq_r ? {30'h0, eor_r, eom_r} : 32'h0, tx_len_r, cid_r, lport_r, pport_r); // RULE21
    end else if (g_cred) begin
      enq_hdr = mk(OP_CREDIT_UPD, 32'h0, 32'h0, cid_r, lport_r, pport_r);
    end else if (!g_rst) begin
      enq = 1'b0;
    end
  end

  // reply store outside the rx queue
  assign deq     = cnt_r != '0 && (!RX_VALID || RX_READY);
  assign cnt_nxt = cnt_r + CW'(enq) - CW'(deq);

  always_ff @(posedge SYS_CLK) begin
    if (enq) begin
      mem[wp_r] <= enq_hdr; // RULE9
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cnt_r    <= '0;
      wp_r     <= '0;
      rp_r     <= '0;
      TX_READY <= 1'b0;
      RX_VALID <= 1'b0;
      RX_HDR   <= '0;
    end else begin
      cnt_r    <= cnt_nxt;
      TX_READY <= cnt_nxt < CW'(DEPTH); // RULE9 RULE10
      if (enq) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (deq) begin
        rp_r     <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        RX_VALID <= 1'b1; // RULE7
        RX_HDR   <= mem[rp_r];
      end else if (RX_READY) begin
        RX_VALID <= 1'b0;
      end
    end
  end

  // software commands; a new request wins over a same-cycle completion
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      send_pend_r <= 1'b0;
      shut_pend_r <= 1'b0;
      cred_pend_r <= 1'b0;
      rst_pend_r  <= 1'b0;
      trst_pend_r <= 1'b0;
    end else begin
      if (g_send || state_r != ST_CONN) send_pend_r <= 1'b0;
      if (g_shut || state_r != ST_CONN) shut_pend_r <= 1'b0;
      if (g_cred || state_r == ST_IDLE) cred_pend_r <= 1'b0;
      if (g_rst || state_r != ST_CLOSING) rst_pend_r <= 1'b0;
      if (trst_go) trst_pend_r <= 1'b0;
      if (state_r == ST_CLOSING && tmr_r == 32'(DISC_CYC_P - 1)) begin
        rst_pend_r <= 1'b1; // RULE20
      end
      if (wr && APB_REQ.paddr == REG_CTRL) begin
        if (wctl.send) send_pend_r <= 1'b1;
        if (wctl.shut) shut_pend_r <= 1'b1;
        if (wctl.cred) cred_pend_r <= 1'b1;
        if (wctl.trst) trst_pend_r <= 1'b1;
      end
    end
  end

  // connection state and credit counters
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_r    <= ST_IDLE;
      lport_r    <= 32'h0;
      pport_r    <= 32'h0;
      peer_ba_r  <= 32'h0;
      peer_fwd_r <= 32'h0;
      tx_cnt_r   <= 32'h0;
      fwd_cnt_r  <= 32'h0;
      shut_r     <= 2'b00;
      tmr_r      <= 32'h0;
    end else begin
      tmr_r <= (state_r == ST_CLOSING) ? tmr_r + 32'h1 : 32'h0;
      if (g_send) tx_cnt_r <= tx_cnt_r + tx_len_r; // RULE13
      if (g_shut) state_r <= ST_CLOSING;
      if (g_rst) state_r <= ST_IDLE;
      if (tx_acc && type_ok) begin
        peer_ba_r  <= h.buf_alloc; // RULE15
        peer_fwd_r <= h.fwd_cnt;
        case (h.op)
          OP_REQUEST: begin
            if (listen_r && state_r == ST_IDLE) begin // RULE18
              state_r   <= ST_CONN;
              lport_r   <= h.dst_port;
              pport_r   <= h.src_port;
              tx_cnt_r  <= 32'h0;
              fwd_cnt_r <= 32'h0;
              shut_r    <= 2'b00;
            end
          end
          OP_RST: state_r <= ST_IDLE; // RULE18 RULE20
          OP_SHUTDOWN: begin
            if (state_r != ST_IDLE) begin
              shut_r <= shut_r | h.flags[1:0]; // RULE19
              if ((shut_r | h.flags[1:0]) == 2'b11) state_r <= ST_IDLE;
            end
          end
          OP_RW: if (state_r != ST_IDLE) fwd_cnt_r <= fwd_cnt_r + h.len; // RULE12
          default: ;
        endcase
      end
      if (trst_go) begin
        state_r <= ST_IDLE; // RULE22
        shut_r  <= 2'b00;
      end
    end
  end

  // transport reset event
  assign trst_go = trst_pend_r && !EVT_VALID;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      EVT_VALID <= 1'b0;
      EVT_ID    <= EVT_TRANSPORT_RESET;
    end else begin
      EVT_ID <= EVT_TRANSPORT_RESET; // RULE22
      if (trst_go) begin
        EVT_VALID <= 1'b1;
      end else if (EVT_READY) begin
        EVT_VALID <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  a_cid_hi_zero: assert property (PREADY && APB_REQ.paddr == REG_CID_HI && !APB_REQ.pwrite |-> PRDATA == 32'h0) // RULE1
    else $error("context id upper word not zero");
  a_cid_not_rsv: assert property (!is_rsv(cid_r)) // RULE2
    else $error("reserved context id held");
  a_hdr_cid_hi: assert property (RX_VALID |-> RX_HDR.src_cid[63:32] == 32'h0 && RX_HDR.dst_cid[63:32] == 32'h0) // RULE5
    else $error("cid upper word not zero");
  a_bad_type_rst: assert property (tx_acc && !type_ok |=> cnt_r == $past(cnt_r) + CW'(1) - CW'($past(deq))) // RULE17
    else $error("unknown type not answered");
  a_credit_reply: assert property (tx_acc && type_ok && h.op == OP_CREDIT_REQ |-> enq && enq_hdr.op == OP_CREDIT_UPD) // RULE14
    else $error("credit request not answered");
  a_req_no_listen: assert property (tx_acc && type_ok && h.op == OP_REQUEST && !listen_r |-> enq_hdr.op == OP_RST) // RULE18
    else $error("request without listener not reset");
  a_rw_credit: assert property (enq && !tx_acc && enq_hdr.op == OP_RW |-> peer_free >= enq_hdr.len) // RULE13
    else $error("payload sent beyond peer credit");
  a_store_stop: assert property (cnt_r == CW'(DEPTH) && !deq |-> !TX_READY ##1 !tx_acc) // RULE10
    else $error("tx taken with store exhausted");
  a_shut_sticky: assert property (shut_r[SHUT_RX_BIT] && state_r != ST_IDLE && !trst_go |=> shut_r[SHUT_RX_BIT]) // RULE19
    else $error("shutdown bit lost");

  sequence s_trst_start;
    trst_pend_r && !EVT_VALID;
  endsequence
  sequence s_evt_shown;
    EVT_VALID && EVT_ID == EVT_TRANSPORT_RESET && state_r == ST_IDLE;
  endsequence
  a_trst_event: assert property (s_trst_start |=> s_evt_shown) // RULE22
    else $error("transport reset event wrong");

endmodule
`default_nettype wire

// File: vsk_drv_model.sv
/*
  behavioural guest driver: posts headers on tx, drains rx and event queues.
  assumes the bench calls send just after a rising edge of SYS_CLK.
*/
`timescale 1ns/10ps
`default_nettype none
module vsk_drv_model
  import vsk_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // tx queue
  output logic             TX_VALID,
  output vsk_hdr_t         TX_HDR,
  input  wire logic        TX_READY,
  // rx queue
  input  wire logic        RX_VALID,
  input  wire vsk_hdr_t    RX_HDR,
  output logic             RX_READY,
  // event queue
  input  wire logic        EVT_VALID,
  input  wire logic [31:0] EVT_ID,
  output logic             EVT_READY,
  // bench control
  input  wire logic        STALL
);
  vsk_hdr_t    rxq[$];
  logic [31:0] evq[$];
  int          hangs = 0;
  initial begin
    TX_VALID = 1'b0;
    TX_HDR = '0;
    RX_READY = 1'b0;
    EVT_READY = 1'b0;
  end
  // rx keeps draining while tx waits unless STALL is high; random gaps make the far side slow
  always @(posedge SYS_CLK) begin
    RX_READY <= !SRST && !STALL && ($urandom_range(3, 0) != 0);
    EVT_READY <= !SRST;
    if (RX_VALID && RX_READY)
      rxq.push_back(RX_HDR);
    if (EVT_VALID && EVT_READY)
      evq.push_back(EVT_ID);
  end
  task automatic send(input vsk_hdr_t h);
    int n;
    TX_HDR <= h;
    TX_VALID <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (TX_READY !== 1'b1 && n < 200);
    if (TX_READY !== 1'b1) begin
      hangs++;
      tb_top.results();
    end
    TX_VALID <= 1'b0;
    // released header is inverted so stale data never looks valid
    TX_HDR <= ~h;
    // one idle edge so a following call never writes valid twice in a step
    @(posedge SYS_CLK);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
/*
  self-checking bench of the socket packet engine with a driver model.
  assumes vsk_engine and vsk_drv_model, one 40 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import vsk_pkg::*;
;
  logic         clk = 0, rst = 1, stall = 0, pready, pslverr, txv, txr, rxv, rxr, evv, evr, er;
  vsk_apb_req_t req = '0;
  logic [31:0]  prdata, evid, rd, cid, ba, pba, pfw, lp, pp, fwd, txc;
  vsk_hdr_t     txh, rxh, h, u;
  logic [31:0]  rsv [5] = '{32'h0, 32'h1, CID_RSV_LOW, CID_RSV_A, CID_RSV_B};
  logic         seq = 0;
  int           mismatches = 0, checks = 0;
  always #12.5 clk = ~clk;
  vsk_engine #(.DEPTH(4), .DISC_CYC_P(20)) DUT (.SYS_CLK(clk), .SRST(rst), .APB_REQ(req),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_VALID(txv), .TX_HDR(txh),
    .TX_READY(txr), .RX_VALID(rxv), .RX_HDR(rxh), .RX_READY(rxr), .EVT_VALID(evv),
    .EVT_ID(evid), .EVT_READY(evr));
  vsk_drv_model drv (.SYS_CLK(clk), .SRST(rst), .TX_VALID(txv), .TX_HDR(txh), .TX_READY(txr),
    .RX_VALID(rxv), .RX_HDR(rxh), .RX_READY(rxr), .EVT_VALID(evv), .EVT_ID(evid),
    .EVT_READY(evr), .STALL(stall));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0 && drv.hangs == 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      results();
    end
    rd = prdata;
    er = pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  function automatic vsk_hdr_t mk(input logic [15:0] op, input logic [31:0] len, input logic [31:0] fl);
    mk = '{{32'h0, cid}, HOST_CID, pp, lp, len, TYPE_STREAM, op, fl, pba, pfw};
  endfunction
  function automatic logic [31:0] pfree();
    return pba - (txc - pfw);
  endfunction
  task automatic exprx(input logic [15:0] op);
    int n;
    n = 0;
    while (drv.rxq.size() == 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      results();
    end
    h = drv.rxq.pop_front();
    chk("op", op, h.op);
    chk("dst cid", {32'h0, cid}, h.dst_cid);
    chk("src cid hi", 0, h.src_cid[63:32]);
    chk("ports", {lp, pp}, {h.src_port, h.dst_port});
    chk("type", seq ? TYPE_SEQPKT : TYPE_STREAM, h.ptype);
    chk("credit", {ba, fwd}, {h.buf_alloc, h.fwd_cnt});
  endtask
  task automatic sendx(input logic [15:0] op, input logic [31:0] fl, input logic [15:0] rop);
    drv.send(mk(op, 32'h0, fl));
    exprx(rop);
  endtask
  initial begin
    void'($urandom(9557));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("cid lo", REG_CID_LO, CID_RESET);
    rdchk("buf alloc", REG_BUF_ALLOC, BUF_ALLOC_RESET);
    apb(1'b1, REG_CID_HI, 32'hffffffff);
    rdchk("cid hi", REG_CID_HI, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("slverr", 1, er);
    foreach (rsv[i]) begin
      apb(1'b1, REG_CID_LO, rsv[i]);
      rdchk("cid kept", REG_CID_LO, CID_RESET);
    end
    apb(1'b0, REG_STATUS, 32'h0);
    chk("cid err", 1, rd[4]);
    cid = $urandom_range(32'h0ffffffe, 3);
    ba = $urandom_range(32'h00ffffff, 32'h100);
    {lp, pp} = {$urandom, $urandom};
    {pba, pfw, fwd, txc} = {32'h40, 96'h0};
    apb(1'b1, REG_CID_LO, cid);
    apb(1'b1, REG_BUF_ALLOC, ba);
    rdchk("cid set", REG_CID_LO, cid);
    $display("done registers");
    u = mk(OP_REQUEST, 32'h0, 32'h0);
    u.ptype = 16'($urandom_range(16'hffff, 3));
    drv.send(u);
    exprx(OP_RST);
    sendx(OP_REQUEST, 32'h0, OP_RST);
    apb(1'b1, REG_CTRL, 32'h1);
    sendx(OP_REQUEST, 32'h0, OP_RESPONSE);
    $display("done connect");
    u = mk(OP_RW, $urandom_range(64, 1), 32'h0);
    fwd = u.len;
    drv.send(u);
    rdchk("fwd cnt", REG_FWD_CNT, fwd);
    sendx(OP_CREDIT_REQ, 32'h0, OP_CREDIT_UPD);
    $display("done credit");
    apb(1'b1, REG_TX_LEN, pba + 1);
    apb(1'b1, REG_CTRL, 32'h5);
    repeat (10) @(posedge clk);
    chk("no send", 0, drv.rxq.size());
    rdchk("peer free", REG_PEER_FREE, pfree());
    apb(1'b1, REG_TX_LEN, pba);
    exprx(OP_RW);
    chk("len", pba, h.len);
    txc += pba;
    rdchk("peer free", REG_PEER_FREE, pfree());
    pfw = pba;
    drv.send(mk(OP_CREDIT_UPD, 32'h0, 32'h0));
    seq = 1;
    apb(1'b1, REG_TX_LEN, 32'h4);
    apb(1'b1, REG_CTRL, 32'h67);
    exprx(OP_RW);
    chk("eom eor", 3, h.flags);
    $display("done payload");
    drv.send(mk(OP_SHUTDOWN, 32'h0, 32'h1));
    drv.send(mk(OP_SHUTDOWN, 32'h0, 32'h0));
    apb(1'b0, REG_STATUS, 32'h0);
    chk("peer shut", 1, rd[1:0]);
    sendx(OP_SHUTDOWN, 32'h2, OP_RST);
    sendx(OP_REQUEST, 32'h0, OP_RESPONSE);
    {fwd, txc} = 64'h0;
    apb(1'b1, REG_CTRL, 32'hb);
    exprx(OP_SHUTDOWN);
    chk("shut flags", 3, h.flags);
    exprx(OP_RST);
    $display("done disconnect");
    sendx(OP_REQUEST, 32'h0, OP_RESPONSE);
    stall <= 1'b1;
    repeat (5) drv.send(mk(OP_CREDIT_REQ, 32'h0, 32'h0));
    repeat (3) @(posedge clk);
    chk("tx ready", 0, txr);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("store full", 1, rd[5]);
    stall <= 1'b0;
    repeat (5) exprx(OP_CREDIT_UPD);
    apb(1'b1, REG_CTRL, 32'h83);
    exprx(OP_CREDIT_UPD);
    rdchk("ctrl", REG_CTRL, 32'h3);
    $display("done backpressure");
    apb(1'b1, REG_CTRL, 32'h13);
    repeat (3) @(posedge clk);
    chk("events", 1, drv.evq.size());
    chk("event id", EVT_TRANSPORT_RESET, drv.evq[0]);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("connected", 0, rd[2]);
    $display("done transport reset");
    results();
  end
endmodule
`default_nettype wire
